// ===== src/wdt_pkg.sv
// Shared constants for the instruction clock watchdog
package wdt_pkg;
  localparam int          CNT_W      = 16;
  localparam logic [15:0] CNT_RESET  = 16'hffff;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam int          INSTR_DIV  = 4;
  localparam logic [3:0]  DIV_LAST   = 4'h3;
  localparam logic [15:0] KICK_LIMIT = 16'hfffe;
endpackage

// ===== src/wdt_if.sv
// Connection between processor core end and watchdog end
`timescale 1ns/1ns
interface wdt_if;
  logic instr_tick;
  logic restart_instr;
  logic disable_instr;
  logic skip_next;
  logic reset_pin_oe;
  modport device (input instr_tick, input restart_instr, input disable_instr,
                  output skip_next, output reset_pin_oe);
  modport core (output instr_tick, output restart_instr,
                output disable_instr, input skip_next, input reset_pin_oe);
endinterface

// ===== src/instruction_clock_watchdog.sv
// Watchdog down counter, flags and reset pin driver
`timescale 1ns/1ns
// Summary of operation
// - After reset count down from ffff per instruction
// - Count past zero sets first underflow flag
// - Underflow with first flag set asserts reset
// - Reset signal drives reset pin low
// - Software restarts within 65534 machine cycles
// - Enable flag set on reset and backup
// - Disable then restart clears enable flag
// - Disable alone keeps watchdog running
// - Restart with first flag clears and skips
// - Restart with first flag clear no skip
// - Skip works even when watchdog disabled
// - Power-down reloads counter and first flag
// - Watchdog re-enabled after power-down return
// - Restart advised just before power-down
module instruction_clock_watchdog
  import wdt_pkg::*;
#(
  parameter int WIDTH = CNT_W              // Down counter width
)
(
  input  wire logic i_sys_clk,       // System clock
  input  wire logic i_srst,          // Synchronous reset, high
  input  wire logic i_power_down,    // Power-down entry pulse
  input  wire logic i_backup_mode,   // RAM back-up entry pulse
  input  wire logic i_reset_pin,     // Level seen on reset pin
  output logic      o_enable_flag,   // Watchdog enable flag
  output logic      o_first_flag,    // First underflow flag
  output logic      o_second_flag,   // Second underflow flag
  wdt_if.device     link             // Core side
);
  logic [WIDTH-1:0] watchdog_down_counter_r;
  logic             pend_disable_r;
  logic             pin_meta_r;
  logic             pin_sync_r;
  logic             wake_r;
  logic             underflow;

  // A narrower counter only shortens the period, for quick tests
  if (WIDTH < 2 || WIDTH > CNT_W) begin : g_bad_width
    $error("watchdog counter width out of range");
  end

  assign underflow = link.instr_tick && o_enable_flag &&
                     (watchdog_down_counter_r == CNT_ZERO[WIDTH-1:0]);

  // Pin level is synchronised and registered in wake_r; no logic reads wake_r
  always_ff @(posedge i_sys_clk) begin
    pin_meta_r <= i_reset_pin;
    pin_sync_r <= pin_meta_r;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_power_down) begin
      watchdog_down_counter_r <= CNT_RESET[WIDTH-1:0];
    end else if (link.instr_tick && o_enable_flag) begin
      watchdog_down_counter_r <= watchdog_down_counter_r
                                 - CNT_ONE[WIDTH-1:0];
    end
  end

  // Pair tracking: a disable is kept only for the very next instruction
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_power_down) begin
      pend_disable_r <= 1'b0;
    end else if (link.instr_tick) begin
      pend_disable_r <= link.disable_instr;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_backup_mode || i_power_down) begin
      o_enable_flag <= 1'b1;
    end else if (link.instr_tick && link.restart_instr && pend_disable_r) begin
      o_enable_flag <= 1'b0;
    end
  end

  // Set wins over clear when underflow meets restart
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_power_down) begin
      o_first_flag <= 1'b0;
    end else if (underflow) begin
      o_first_flag <= 1'b1;
    end else if (link.instr_tick && link.restart_instr) begin
      o_first_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_second_flag     <= 1'b0;
      link.reset_pin_oe <= 1'b0;
    end else if (underflow && o_first_flag) begin
      o_second_flag     <= 1'b1;
      link.reset_pin_oe <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      link.skip_next <= 1'b0;
      wake_r         <= 1'b0;
    end else begin
      wake_r <= pin_sync_r;
      if (link.instr_tick) begin
        link.skip_next <= link.restart_instr && o_first_flag;
      end
    end
  end
endmodule // instruction_clock_watchdog

// ===== src/watchdog_core_end.sv
// Processor core end issuing restart and disable instructions
`timescale 1ns/1ns
module watchdog_core_end
  import wdt_pkg::*;
#(
  parameter logic [15:0] LIMIT = KICK_LIMIT  // Slots allowed between restarts
)
(
  input  wire logic i_sys_clk,     // System clock
  input  wire logic i_srst,        // Synchronous reset, high
  input  wire logic i_restart,     // Request restart instruction
  input  wire logic i_disable,     // Request disable instruction
  output logic      o_skipped,     // Last instruction was skipped
  output logic      o_kick_late,   // Restart gap exceeded limit
  wdt_if.core       link           // Watchdog side
);
  logic [3:0]  div_r;
  logic [15:0] gap_r;

  if (LIMIT == 16'h0000) begin : g_bad_limit
    $error("restart gap limit must be nonzero");
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      div_r           <= 4'h0;
      link.instr_tick <= 1'b0;
    end else begin
      div_r           <= (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
      link.instr_tick <= (div_r == DIV_LAST);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      link.restart_instr <= 1'b0;
      link.disable_instr <= 1'b0;
    end else if (div_r == DIV_LAST) begin
      link.restart_instr <= i_restart;
      link.disable_instr <= i_disable && !i_restart;
    end
  end

  // Counts machine cycles between restarts
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      gap_r       <= 16'h0000;
      o_kick_late <= 1'b0;
      o_skipped   <= 1'b0;
    end else if (link.instr_tick) begin
      o_skipped <= link.skip_next;
      if (link.restart_instr) begin
        gap_r <= 16'h0000;
      end else if (gap_r != LIMIT) begin
        gap_r <= gap_r + 16'h0001;
      end else begin
        o_kick_late <= 1'b1;
      end
    end
  end
endmodule // watchdog_core_end

// ===== verif/wdt_link_properties.sv
// Interface property checks for the watchdog link
`timescale 1ns/1ns
module wdt_link_properties (
  input wire logic i_sys_clk,     // Clock
  input wire logic i_srst,        // Reset
  input wire logic instr_tick,    // Slot pulse
  input wire logic restart_instr, // Restart
  input wire logic disable_instr, // Disable
  input wire logic skip_next,     // Skip
  input wire logic reset_pin_oe   // Pin drive
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  tick_gap_a: assert property (
    instr_tick |=> !instr_tick [*3] ##1 instr_tick) else $error("tick gap");
  oe_sticky_a: assert property (
    reset_pin_oe |=> reset_pin_oe) else $error("pin drive dropped");
  oe_cause_a: assert property (
    $rose(reset_pin_oe) |-> $past(instr_tick)) else $error("pin off slot");
  skip_hold_a: assert property (
    !instr_tick |=> $stable(skip_next)) else $error("skip moved");
  skip_cause_a: assert property (
    $rose(skip_next) |-> $past(instr_tick && restart_instr))
    else $error("skip without restart");
  no_skip_a: assert property (
    instr_tick && !restart_instr |=> !skip_next) else $error("stray skip");
  clean_start_a: assert property (
    $fell(i_srst) |-> !reset_pin_oe && !skip_next) else $error("reset state");
  one_instr_a: assert property (
    instr_tick |-> !(restart_instr && disable_instr)) else $error("two instr");
  cover property (instr_tick && restart_instr);
  cover property (instr_tick && disable_instr ##4 instr_tick && restart_instr);
  cover property ($fell(i_srst));
  cover property ($rose(reset_pin_oe));
endmodule // wdt_link_properties

// ===== verif/testbench.sv
// Self-checking bench for both watchdog ends
`timescale 1ns/1ns
module testbench;
  import wdt_pkg::*;
  logic sys_clk = 0, srst = 1, pd = 0, bk = 0, rs = 0, ds = 0;
  logic en, f1, f2, skp, late, pin;
  int   miscompares = 0, checks = 0, cyc = 0;
  // Three slots (0 nop, 1 restart, 2 disable), then enable and skip
  logic [7:0] rows [5] = '{8'h82, 8'h86, 8'h42, 8'h90, 8'h40};
  wdt_if w ();
  assign pin = ~w.reset_pin_oe;
  // Short counter and gap limit so underflows fit in the run
  instruction_clock_watchdog #(.WIDTH(4)) i_instruction_clock_watchdog (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_power_down(pd),
    .i_backup_mode(bk), .i_reset_pin(pin), .o_enable_flag(en),
    .o_first_flag(f1), .o_second_flag(f2), .link(w));
  watchdog_core_end #(.LIMIT(16'h000e)) i_watchdog_core_end (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_restart(rs), .i_disable(ds),
    .o_skipped(skp), .o_kick_late(late), .link(w));
  wdt_link_properties i_wdt_link_properties (
    .i_sys_clk(sys_clk), .i_srst(srst), .instr_tick(w.instr_tick),
    .restart_instr(w.restart_instr), .disable_instr(w.disable_instr),
    .skip_next(w.skip_next), .reset_pin_oe(w.reset_pin_oe));
  always #50 sys_clk = ~sys_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request held over a whole instruction slot
  task automatic slot(input logic [1:0] c);
    rs <= c[0];
    ds <= c[1];
    repeat (INSTR_DIV) @(posedge sys_clk);
  endtask
  task automatic off_pair();
    slot(2'h2);
    slot(2'h1);
    slot(2'h0);
    slot(2'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    @(posedge sys_clk);
    check({en, f1, f2, w.reset_pin_oe, skp, late}, 8'h20);
    foreach (rows[i]) begin
      for (int k = 3; k > 0; k--) slot(rows[i][2*k+1 -: 2]);
      slot(2'h0);
      slot(2'h0);
      check({en, skp}, rows[i][1:0]);
    end
    bk <= 1;
    @(posedge sys_clk);
    bk <= 0;
    repeat (2) @(posedge sys_clk);
    check(en, 8'h1);
    off_pair();
    check(en, 8'h0);
    slot(2'h1);
    pd <= 1;
    @(posedge sys_clk);
    pd <= 0;
    repeat (2) @(posedge sys_clk);
    check({en, f1}, 8'h2);
    off_pair();
    srst <= 1;
    @(posedge sys_clk);
    srst <= 0;
    @(posedge sys_clk);
    check({en, f1, f2, skp}, 8'h8);
    repeat (16) slot(2'h0);
    @(negedge sys_clk);
    check({en, f1, f2}, 8'h6);
    slot(2'h1);
    @(negedge sys_clk);
    check({w.skip_next, f1}, 8'h2);
    repeat (31) slot(2'h0);
    @(negedge sys_clk);
    check({f1, f2, w.reset_pin_oe, pin, late}, 8'h1d);
    stop_test();
  end
endmodule // testbench
